// [shared/scm_pkg.sv]
// Shared constants, types and register map of the system clock and mode control block
package scm_pkg;

    // ----------------------------------------------------------------
    // Register map
    // ----------------------------------------------------------------
    localparam int          ADDR_W     = 5;
    localparam logic [4:0]  ADDR_SCC   = 5'h00;
    localparam logic [4:0]  ADDR_FAST_RC_CONTROL = 5'h04;
    localparam logic [4:0]  ADDR_FAST_CRYSTAL_CONTROL  = 5'h08;
    localparam logic [4:0]  ADDR_SLOW_CRYSTAL_CONTROL  = 5'h0c;
    localparam logic [4:0]  ADDR_STAT  = 5'h10;
    localparam logic [2:0]  SIZE_WORD  = 3'h2;

    // ----------------------------------------------------------------
    // Field positions
    // ----------------------------------------------------------------
    localparam int SCC_CKS_LSB    = 5;
    localparam int SCC_FHS        = 3;
    localparam int SCC_FSS        = 2;
    localparam int SCC_FKH        = 1;
    localparam int SCC_SKH        = 0;
    localparam int FAST_RC_CONTROL_FREQ_LSB = 2;
    localparam int OSC_FLAG       = 1;
    localparam int OSC_EN         = 0;
    localparam int FAST_CRYSTAL_CONTROL_MODE      = 2;
    localparam int SLOW_CRYSTAL_CONTROL_SPEED     = 2;
    localparam int STAT_MODE_LSB  = 0;
    localparam int STAT_FAST      = 3;
    localparam int STAT_BUSY      = 4;
    localparam int STAT_CPU       = 5;

    // ----------------------------------------------------------------
    // Values
    // ----------------------------------------------------------------
    localparam logic [2:0] CKS_SUB            = 3'h7;
    localparam logic [1:0] FREQ_8M_ALIAS      = 2'h3;
    localparam logic [1:0] FREQ_8M            = 2'h0;
    localparam logic       INTERNAL_FAST_RC_EN_RST        = 1'b1;
    localparam logic       LXT_SPEED_VAL      = 1'b1;
    localparam logic [2:0] SWITCH_SYS_PERIODS = 3'h4;

    typedef enum logic [2:0] {
        MODE_RUN   = 3'h0,
        MODE_SLEEP = 3'h1,
        MODE_IDLE_SLOW_ONLY = 3'h3,
        MODE_IDLE_BOTH_OSC = 3'h2,
        MODE_IDLE_FAST_ONLY = 3'h6
    } scm_mode_t;

    typedef struct packed {
        logic sys;
        logic fast;
        logic sub;
        logic slow_rc;
    } scm_clk_en_t;

    typedef struct packed {
        logic fast_rc;
        logic fast_xtal;
        logic slow_rc;
        logic slow_xtal;
    } scm_osc_on_t;

    typedef struct packed {
        logic              ph_valid;
        logic              ph_wr;
        logic [ADDR_W-1:0] ph_addr;
        logic              hready;
        logic [31:0]       rdata;
        logic [2:0]        cks;
        logic              fast_source_select;
        logic              slow_source_select;
        logic              fkh;
        logic              skh;
        logic [1:0]        internal_fast_rc_freq;
        logic              internal_fast_rc_en;
        logic              internal_fast_rc_restart;
        logic              hxt_mode;
        logic              hxt_en;
        logic              lxt_en;
        logic [2:0]        cur_cks;
        logic              cur_fhs;
        logic              cur_fss;
        logic              sw_busy;
        logic [2:0]        sw_cnt;
        scm_mode_t         mode;
        logic              cpu_run;
        scm_clk_en_t       clk;
        scm_osc_on_t       osc;
    } scm_state_t;

endpackage

// [src/scm_fdiv.sv]
// Power-of-two divider of the fast clock tick, ratio 1 to 64
`timescale 1ns/10ps
`default_nettype none
module scm_fdiv
    import scm_pkg::*;
#(
    parameter int DIV_W = 6
)(
    input  wire logic       hclk,
    input  wire logic       hresetn,
    input  wire logic       tick_in,
    input  wire logic [2:0] ratio_log2,
    output logic            tick_out
);

    typedef struct packed {
        logic [DIV_W-1:0] cnt;
        logic             out;
    } scm_div_st_t;

    scm_div_st_t      st;
    scm_div_st_t      n;
    logic [DIV_W:0]   wide_mask;
    logic [DIV_W-1:0] last;

    always_comb
    begin
        wide_mask = ((DIV_W + 1)'(1) << ratio_log2) - (DIV_W + 1)'(1);
        last      = wide_mask[DIV_W-1:0];
        n         = st;
        n.out     = 1'b0;
        if (tick_in)
        begin
            if (st.cnt >= last)
            begin
                n.cnt = '0;
                n.out = 1'b1;
            end
            else
            begin
                n.cnt = st.cnt + DIV_W'(1);
            end
        end
    end

    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            st <= '0;
        end
        else
        begin
            st <= n;
        end
    end

    assign tick_out = st.out;

endmodule
`default_nettype wire

// [src/scm_osc_in.sv]
// Oscillator input synchroniser, edge tick and start-up stability counter
`timescale 1ns/10ps
`default_nettype none
module scm_osc_in
    import scm_pkg::*;
#(
    parameter int STAB_EDGES = 1024
)(
    input  wire logic hclk,
    input  wire logic hresetn,
    input  wire logic osc_pin,
    input  wire logic enable,
    input  wire logic restart,
    output logic      tick,
    output logic      stable
);

    localparam int CW = $clog2(STAB_EDGES + 1);
    localparam logic [CW-1:0] STAB_LAST = CW'(STAB_EDGES);

    typedef struct packed {
        logic          s1;
        logic          s2;
        logic          s3;
        logic          lvl;
        logic          tick;
        logic          stable;
        logic [CW-1:0] cnt;
    } scm_osc_st_t;

    scm_osc_st_t st;
    scm_osc_st_t n;

    always_comb
    begin
        n = st;
        n.s1 = osc_pin;
        n.s2 = st.s1;
        n.s3 = st.s2;
        // A level counts only once two later stages agree
        if (st.s2 == st.s3)
        begin
            n.lvl = st.s3;
        end
        n.tick = n.lvl && !st.lvl;
        // Flag is held low while disabled and drops on restart, then rises after enough edges
        if (!enable || restart)
        begin
            n.cnt    = '0;
            n.stable = 1'b0;
        end
        else if (st.tick && (st.cnt != STAB_LAST))
        begin
            n.cnt = st.cnt + CW'(1);
        end
        else if (st.cnt == STAB_LAST)
        begin
            n.stable = 1'b1;
        end
    end

    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            st <= '0;
        end
        else
        begin
            st <= n;
        end
    end

    assign tick   = st.tick;
    assign stable = st.stable;

endmodule
`default_nettype wire

// [src/scm_top.sv]
// System clock selection and operating mode control with AHB-Lite register access
`timescale 1ns/10ps
`default_nettype none
// Function
// - select code picks fast divide or sub
// - fast source bit picks RC or crystal
// - slow source bit picks RC or crystal
// - fast keep bit holds fast osc in halt
// - halt with keeps low enters sleep
// - sleep keeps slow RC only for watchdog
// - halt fast-low slow-high enters idle slow-only
// - halt both keeps high enters idle both
// - halt fast-high slow-low enters idle fast-only
// - fast mode runs divided fast, selected and enabled oscillators on
// - slow mode runs sub, fast per enable
// - CPU runs only in fast and slow
// - bit four reads zero, reset zero
// - RC frequency code 11 means 8MHz
// - enabling clears stable flag until stable
// - switch waits four system periods then target
module scm_top
    import scm_pkg::*;
#(
    parameter int FAST_STAB_EDGES = 1024,
    parameter int SLOW_STAB_EDGES = 1024
)(
    input  wire logic        hclk,
    input  wire logic        hresetn,
    input  wire logic        hsel,
    input  wire logic [31:0] haddr,
    input  wire logic [1:0]  htrans,
    input  wire logic        hwrite,
    input  wire logic [2:0]  hsize,
    input  wire logic [31:0] hwdata,
    input  wire logic        hready,
    output logic             hreadyout,
    output logic [31:0]      hrdata,
    output logic             hresp,
    input  wire logic        fast_rc_pin,
    input  wire logic        fast_xtal_pin,
    input  wire logic        slow_rc_pin,
    input  wire logic        slow_xtal_pin,
    input  wire logic        halt_req,
    input  wire logic        wake_req,
    input  wire logic        wdt_enable,
    output scm_clk_en_t      clk_en,
    output scm_osc_on_t      osc_on,
    output logic             cpu_run,
    output scm_mode_t        power_mode,
    output logic [1:0]       fast_rc_freq,
    output logic             fast_crystal_drive_mode
);

    scm_state_t st;
    scm_state_t n;

    logic internal_fast_rc_tick, hxt_tick, internal_slow_rc_tick, lxt_tick;
    logic internal_fast_rc_stable, hxt_stable, lxt_stable;
    logic fast_tick, sub_tick, div_tick, cur_sys_tick, tgt_tick;
    logic fast_allowed, slow_allowed, run;

    // ----------------------------------------------------------------
    // Oscillator inputs and divider
    // ----------------------------------------------------------------
    scm_osc_in #(.STAB_EDGES(FAST_STAB_EDGES)) u_internal_fast_rc (
        .hclk    (hclk),
        .hresetn (hresetn),
        .osc_pin (fast_rc_pin),
        .enable  (st.osc.fast_rc),
        .restart (st.internal_fast_rc_restart),
        .tick    (internal_fast_rc_tick),
        .stable  (internal_fast_rc_stable)
    );
    scm_osc_in #(.STAB_EDGES(FAST_STAB_EDGES)) u_hxt (
        .hclk    (hclk),
        .hresetn (hresetn),
        .osc_pin (fast_xtal_pin),
        .enable  (st.osc.fast_xtal),
        .restart (1'b0),
        .tick    (hxt_tick),
        .stable  (hxt_stable)
    );
    scm_osc_in #(.STAB_EDGES(SLOW_STAB_EDGES)) u_internal_slow_rc (
        .hclk    (hclk),
        .hresetn (hresetn),
        .osc_pin (slow_rc_pin),
        .enable  (st.osc.slow_rc),
        .restart (1'b0),
        .tick    (internal_slow_rc_tick),
        .stable  ()
    );
    scm_osc_in #(.STAB_EDGES(SLOW_STAB_EDGES)) u_lxt (
        .hclk    (hclk),
        .hresetn (hresetn),
        .osc_pin (slow_xtal_pin),
        .enable  (st.osc.slow_xtal),
        .restart (1'b0),
        .tick    (lxt_tick),
        .stable  (lxt_stable)
    );

    assign fast_tick = st.cur_fhs ? hxt_tick : internal_fast_rc_tick;
    assign sub_tick  = st.cur_fss ? lxt_tick : internal_slow_rc_tick;

    scm_fdiv u_div (
        .hclk       (hclk),
        .hresetn    (hresetn),
        .tick_in    (fast_tick),
        .ratio_log2 (st.cur_cks),
        .tick_out   (div_tick)
    );

    // ----------------------------------------------------------------
    // Register read view
    // ----------------------------------------------------------------
    function automatic logic [31:0] scm_read(input scm_state_t s, input logic [ADDR_W-1:0] a,
                                             input logic f_internal_fast_rc, input logic f_hxt, input logic f_lxt);
        logic [31:0] r;
        r = '0;
        case (a)
            ADDR_SCC:
            begin
                r[SCC_CKS_LSB +: 3] = s.cks;
                r[SCC_FHS]          = s.fast_source_select;
                r[SCC_FSS]          = s.slow_source_select;
                r[SCC_FKH]          = s.fkh;
                r[SCC_SKH]          = s.skh;
            end
            ADDR_FAST_RC_CONTROL:
            begin
                r[FAST_RC_CONTROL_FREQ_LSB +: 2] = s.internal_fast_rc_freq;
                r[OSC_FLAG]            = f_internal_fast_rc;
                r[OSC_EN]              = s.internal_fast_rc_en;
            end
            ADDR_FAST_CRYSTAL_CONTROL:
            begin
                r[FAST_CRYSTAL_CONTROL_MODE] = s.hxt_mode;
                r[OSC_FLAG]  = f_hxt;
                r[OSC_EN]    = s.hxt_en;
            end
            ADDR_SLOW_CRYSTAL_CONTROL:
            begin
                r[SLOW_CRYSTAL_CONTROL_SPEED] = LXT_SPEED_VAL;
                r[OSC_FLAG]   = f_lxt;
                r[OSC_EN]     = s.lxt_en;
            end
            ADDR_STAT:
            begin
                r[STAT_MODE_LSB +: 3] = s.mode;
                r[STAT_FAST]          = (s.cur_cks != CKS_SUB);
                r[STAT_BUSY]          = s.sw_busy;
                r[STAT_CPU]           = s.cpu_run;
            end
            default:
            begin
                r = '0;
            end
        endcase
        return r;
    endfunction

    // ----------------------------------------------------------------
    // Next state
    // ----------------------------------------------------------------
    always_comb
    begin
        n              = st;
        n.internal_fast_rc_restart = 1'b0;
        run            = (st.mode == MODE_RUN);
        // Writes land in the data phase
        if (st.ph_valid && st.ph_wr)
        begin
            case (st.ph_addr)
                ADDR_SCC:
                begin
                    n.cks = hwdata[SCC_CKS_LSB +: 3];
                    n.fast_source_select = hwdata[SCC_FHS];
                    n.slow_source_select = hwdata[SCC_FSS];
                    n.fkh = hwdata[SCC_FKH];
                    n.skh = hwdata[SCC_SKH];
                end
                ADDR_FAST_RC_CONTROL:
                begin
                    n.internal_fast_rc_freq    = hwdata[FAST_RC_CONTROL_FREQ_LSB +: 2];
                    n.internal_fast_rc_en      = hwdata[OSC_EN];
                    // New frequency is trusted only after a fresh stable flag
                    n.internal_fast_rc_restart = (hwdata[OSC_EN] && !st.internal_fast_rc_en) ||
                                     (hwdata[FAST_RC_CONTROL_FREQ_LSB +: 2] != st.internal_fast_rc_freq);
                end
                ADDR_FAST_CRYSTAL_CONTROL:
                begin
                    // Drive strength is frozen while the crystal enable bit is set
                    if (!st.hxt_en)
                    begin
                        n.hxt_mode = hwdata[FAST_CRYSTAL_CONTROL_MODE];
                    end
                    n.hxt_en = hwdata[OSC_EN];
                end
                ADDR_SLOW_CRYSTAL_CONTROL:
                begin
                    n.lxt_en = hwdata[OSC_EN];
                end
                default:
                begin
                end
            endcase
        end
        // Zero-wait slave: the read word is taken in the address phase
        n.hready   = 1'b1;
        n.ph_valid = hsel && hready && htrans[1] && (hsize == SIZE_WORD);
        n.ph_wr    = hwrite;
        n.ph_addr  = haddr[ADDR_W-1:0];
        n.rdata    = '0;
        if (n.ph_valid && !hwrite && (haddr[31:ADDR_W] == '0))
        begin
            n.rdata = scm_read(n, haddr[ADDR_W-1:0], internal_fast_rc_stable, hxt_stable, lxt_stable);
        end

        // Clock switch: four current system periods, then the next target edge
        // Gate on the mode too, so the system clock stops on the same edge that the CPU halts
        cur_sys_tick = run && st.cpu_run && ((st.cur_cks == CKS_SUB) ? sub_tick : div_tick);
        if (st.cks == CKS_SUB)
        begin
            tgt_tick = st.slow_source_select ? lxt_tick : internal_slow_rc_tick;
        end
        else
        begin
            tgt_tick = st.fast_source_select ? hxt_tick : internal_fast_rc_tick;
        end
        if (!st.sw_busy)
        begin
            if ((st.cks != st.cur_cks) || (st.fast_source_select != st.cur_fhs) || (st.slow_source_select != st.cur_fss))
            begin
                n.sw_busy = 1'b1;
                n.sw_cnt  = '0;
            end
        end
        else if (st.sw_cnt != SWITCH_SYS_PERIODS)
        begin
            if (cur_sys_tick)
            begin
                n.sw_cnt = st.sw_cnt + 3'h1;
            end
        end
        else if (tgt_tick)
        begin
            n.cur_cks = st.cks;
            n.cur_fhs = st.fast_source_select;
            n.cur_fss = st.slow_source_select;
            n.sw_busy = 1'b0;
        end

        // Operating mode
        case (st.mode)
            MODE_RUN:
            begin
                if (halt_req)
                begin
                    case ({st.fkh, st.skh})
                        2'b00:   n.mode = MODE_SLEEP;
                        2'b01:   n.mode = MODE_IDLE_SLOW_ONLY;
                        2'b11:   n.mode = MODE_IDLE_BOTH_OSC;
                        default: n.mode = MODE_IDLE_FAST_ONLY;
                    endcase
                end
            end
            MODE_SLEEP, MODE_IDLE_SLOW_ONLY, MODE_IDLE_BOTH_OSC, MODE_IDLE_FAST_ONLY:
            begin
                if (wake_req)
                begin
                    n.mode = MODE_RUN;
                end
            end
            default:
            begin
                n.mode = MODE_RUN;
            end
        endcase
        n.cpu_run = (st.mode == MODE_RUN);

        // Oscillators kept on per mode
        fast_allowed = run || (st.mode == MODE_IDLE_BOTH_OSC) || (st.mode == MODE_IDLE_FAST_ONLY);
        slow_allowed = run || (st.mode == MODE_IDLE_SLOW_ONLY) || (st.mode == MODE_IDLE_BOTH_OSC);
        // In fast mode the selected source cannot be stopped; in slow mode only its enable holds it
        n.osc.fast_rc   = fast_allowed && (st.internal_fast_rc_en ||
                          (!st.cur_fhs && ((st.cur_cks != CKS_SUB) || !run)));
        n.osc.fast_xtal = fast_allowed && (st.hxt_en ||
                          (st.cur_fhs && ((st.cur_cks != CKS_SUB) || !run)));
        n.osc.slow_xtal = slow_allowed && (st.lxt_en || st.cur_fss);
        n.osc.slow_rc   = !((st.mode == MODE_SLEEP) && !wdt_enable);

        n.clk.sys     = cur_sys_tick;
        n.clk.fast    = fast_allowed && fast_tick &&
                        (st.cur_fhs ? st.osc.fast_xtal : st.osc.fast_rc);
        n.clk.sub     = slow_allowed && sub_tick;
        n.clk.slow_rc = st.osc.slow_rc && internal_slow_rc_tick;
    end

    // ----------------------------------------------------------------
    // State register
    // ----------------------------------------------------------------
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            st <= '{hready: 1'b1, internal_fast_rc_en: INTERNAL_FAST_RC_EN_RST, mode: MODE_RUN, cpu_run: 1'b1,
                    osc: '{fast_rc: 1'b1, fast_xtal: 1'b0, slow_rc: 1'b1, slow_xtal: 1'b0},
                    default: '0};
        end
        else
        begin
            st <= n;
        end
    end

    assign hreadyout               = st.hready;
    assign hrdata                  = st.rdata;
    assign hresp                   = 1'b0;
    assign clk_en                  = st.clk;
    assign osc_on                  = st.osc;
    assign cpu_run                 = st.cpu_run;
    assign power_mode              = st.mode;
    // Code 11 aliases the 8MHz setting
    assign fast_rc_freq            = (st.internal_fast_rc_freq == FREQ_8M_ALIAS) ? FREQ_8M : st.internal_fast_rc_freq;
    assign fast_crystal_drive_mode = st.hxt_mode;

    // ----------------------------------------------------------------
    // Assertions
    // ----------------------------------------------------------------
    AST_SLEEP_ENTRY: assert property (@(posedge hclk) disable iff (!hresetn)
        (st.mode == MODE_RUN) && halt_req && !st.fkh && !st.skh |=> (st.mode == MODE_SLEEP) ##1 !st.cpu_run)
        else $error("halt with keeps low did not sleep");
    AST_IDLE_SLOW_ONLY_ENTRY: assert property (@(posedge hclk) disable iff (!hresetn)
        (st.mode == MODE_RUN) && halt_req && !st.fkh && st.skh |=> (st.mode == MODE_IDLE_SLOW_ONLY) ##1 !st.osc.fast_rc)
        else $error("idle slow-only not entered");
    AST_IDLE_BOTH_OSC_ENTRY: assert property (@(posedge hclk) disable iff (!hresetn)
        (st.mode == MODE_RUN) && halt_req && st.fkh && st.skh |=> (st.mode == MODE_IDLE_BOTH_OSC))
        else $error("idle both not entered");
    AST_IDLE_FAST_ONLY_ENTRY: assert property (@(posedge hclk) disable iff (!hresetn)
        (st.mode == MODE_RUN) && halt_req && st.fkh && !st.skh |=> (st.mode == MODE_IDLE_FAST_ONLY) ##1 !st.osc.slow_xtal)
        else $error("idle fast-only not entered");
    AST_CPU_OFF: assert property (@(posedge hclk) disable iff (!hresetn)
        (st.mode != MODE_RUN) |=> !st.cpu_run && !st.clk.sys)
        else $error("cpu ran in power-saving mode");
    AST_SLEEP_INTERNAL_SLOW_RC: assert property (@(posedge hclk) disable iff (!hresetn)
        (st.mode == MODE_SLEEP) && !wdt_enable |=> !st.osc.slow_rc)
        else $error("slow rc ran in sleep without watchdog");
    AST_BIT4_ZERO: assert property (@(posedge hclk) disable iff (!hresetn)
        st.ph_valid && !st.ph_wr && (st.ph_addr == ADDR_SCC) |-> (hrdata[SCC_CKS_LSB-1] == 1'b0))
        else $error("unimplemented bit read nonzero");
    AST_SWITCH_WAIT: assert property (@(posedge hclk) disable iff (!hresetn)
        st.sw_busy && (st.sw_cnt != SWITCH_SYS_PERIODS) |=> $stable(st.cur_cks) && $stable(st.cur_fhs))
        else $error("clock switched before four system periods");
    AST_STABLE_CLEAR: assert property (@(posedge hclk) disable iff (!hresetn)
        !st.osc.fast_xtal |=> !hxt_stable)
        else $error("stable flag high while oscillator off");
    AST_SUB_ROUTE: assert property (@(posedge hclk) disable iff (!hresetn)
        (st.mode == MODE_RUN) && st.cpu_run && (st.cur_cks == CKS_SUB) && sub_tick |=> st.clk.sys)
        else $error("sub clock not routed to system clock");

endmodule
`default_nettype wire

// [verification/scm_top_tb_top.sv]
// Self-checking bench for the system clock and operating mode control block
`timescale 1ns/10ps
`default_nettype none
module scm_top_tb_top;
    import scm_pkg::*;
    logic        hclk = 1'b0;
    logic        hresetn = 1'b0;
    logic        hsel = 1'b0;
    logic        hwrite = 1'b0;
    logic        halt_req = 1'b0;
    logic        wake_req = 1'b0;
    logic        wdt_enable = 1'b0;
    logic [1:0]  htrans = 2'h0;
    logic [2:0]  hsize = 3'h0;
    logic [31:0] haddr = 32'h0;
    logic [31:0] hwdata = 32'h0;
    logic [31:0] hrdata;
    logic [31:0] rd;
    logic [15:0] cyc = 16'h0;
    logic        hreadyout;
    logic        hresp;
    logic        cpu_run;
    logic [1:0]  fast_rc_freq;
    scm_clk_en_t clk_en;
    scm_osc_on_t osc_on;
    scm_mode_t   power_mode;
    int          miscompares = 0;
    int          comparisons = 0;
    int          tmo = 0;

    // ----------------------------------------------------------------
    // Clock, oscillator waveforms, design
    // ----------------------------------------------------------------
    always #25 hclk = ~hclk;
    // Oscillator periods of 4, 8, 32 and 64 hclk keep every phase at least 2 hclk
    always @(posedge hclk) cyc <= cyc + 16'h1;

    scm_top #(.FAST_STAB_EDGES(4), .SLOW_STAB_EDGES(4)) scm_top_i (
        .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
        .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
        .hreadyout(hreadyout), .hrdata(hrdata), .hresp(hresp),
        .fast_rc_pin(cyc[1]), .fast_xtal_pin(cyc[2]), .slow_rc_pin(cyc[4]), .slow_xtal_pin(cyc[5]),
        .halt_req(halt_req), .wake_req(wake_req), .wdt_enable(wdt_enable), .clk_en(clk_en),
        .osc_on(osc_on), .cpu_run(cpu_run), .power_mode(power_mode),
        .fast_rc_freq(fast_rc_freq), .fast_crystal_drive_mode());

    // ----------------------------------------------------------------
    // Tasks
    // ----------------------------------------------------------------
    task automatic close_out();
        $display("Comparisons %0d, miscompares %0d", comparisons, miscompares);
        if (miscompares == 0 && comparisons > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        comparisons++;
        if (seen !== exp)
        begin
            miscompares++;
            $display("ERROR t=%0t seen=%h expected=%h", $time, seen, exp);
        end
    endtask

    task automatic bus(input logic wr, input logic [4:0] a, input logic [31:0] d);
        @(posedge hclk);
        hsel   <= 1'b1;
        htrans <= 2'h2;
        hwrite <= wr;
        hsize  <= SIZE_WORD;
        haddr  <= {27'h0, a};
        @(posedge hclk);
        while (hreadyout !== 1'b1) @(posedge hclk);
        htrans <= 2'h0;
        hwdata <= d;
        @(posedge hclk);
        while (hreadyout !== 1'b1) @(posedge hclk);
        rd = hrdata;
    endtask

    task automatic rchk(input logic [4:0] a, input logic [31:0] m, input logic [31:0] exp);
        bus(1'b0, a, 32'h0);
        check(rd & m, exp);
    endtask

    // Writes the select register and waits out any clock switch it starts
    task automatic set_scc(input logic [7:0] v);
        bus(1'b1, ADDR_SCC, {24'h0, v});
        repeat (2) @(posedge hclk);
        for (int i = 0; i < 1000; i++)
        begin
            bus(1'b0, ADDR_STAT, 32'h0);
            if (rd[STAT_BUSY] === 1'b0)
                break;
        end
    endtask

    // Ticks of the system clock enable over 1024 hclk, one tick of slack for phase
    task automatic cnt(input int exp);
        int n;
        n = 0;
        repeat (1024)
        begin
            @(posedge hclk);
            if (clk_en.sys === 1'b1)
                n++;
        end
        check({31'h0, (n >= exp - 1) && (n <= exp + 1)}, 32'h1);
    endtask

    always @(posedge hclk)
    begin
        tmo++;
        if (tmo == 80000)
        begin
            miscompares++;
            close_out();
        end
    end

    // ----------------------------------------------------------------
    // Tests
    // ----------------------------------------------------------------
    initial
    begin
        logic [7:0] sv [10] = '{8'h20, 8'h40, 8'h60, 8'h80, 8'ha0, 8'hc0, 8'he0, 8'h08, 8'he4, 8'h00};
        int         ex [10] = '{128, 64, 32, 16, 8, 4, 32, 128, 16, 256};
        logic [1:0] kp [5] = '{2'h0, 2'h0, 2'h1, 2'h3, 2'h2};
        logic       wd [5] = '{1'b0, 1'b1, 1'b0, 1'b0, 1'b0};
        scm_mode_t  md [5] = '{MODE_SLEEP, MODE_SLEEP, MODE_IDLE_SLOW_ONLY, MODE_IDLE_BOTH_OSC, MODE_IDLE_FAST_ONLY};
        logic [1:0] os [5] = '{2'h0, 2'h1, 2'h1, 2'h3, 2'h2};
        repeat (3) @(posedge hclk);
        hresetn <= 1'b1;
        rchk(ADDR_SCC, 32'hff, 32'h00);
        rchk(ADDR_FAST_RC_CONTROL, 32'hfd, 32'h01);
        rchk(ADDR_FAST_CRYSTAL_CONTROL, 32'hff, 32'h00);
        rchk(ADDR_SLOW_CRYSTAL_CONTROL, 32'hfd, 32'h04);
        rchk(5'h14, 32'hffffffff, 32'h0);
        bus(1'b1, ADDR_SCC, 32'hff);
        rchk(ADDR_SCC, 32'hffffffff, 32'hef);
        set_scc(8'h00);
        for (int f = 0; f < 4; f++)
        begin
            bus(1'b1, ADDR_FAST_RC_CONTROL, {28'h0, f[1:0], 2'h1});
            @(posedge hclk);
            check({30'h0, fast_rc_freq}, (f == 3) ? 32'h0 : f);
        end
        bus(1'b1, ADDR_SLOW_CRYSTAL_CONTROL, 32'h1);
        rchk(ADDR_SLOW_CRYSTAL_CONTROL, 32'hff, 32'h05);
        repeat (600) @(posedge hclk);
        rchk(ADDR_SLOW_CRYSTAL_CONTROL, 32'hff, 32'h07);
        bus(1'b1, ADDR_FAST_CRYSTAL_CONTROL, 32'h1);
        for (int i = 0; i < 10; i++)
        begin
            bus(1'b1, ADDR_SCC, {24'h0, sv[i]});
            rchk(ADDR_STAT, 32'h10, 32'h10);
            set_scc(sv[i]);
            cnt(ex[i]);
        end
        for (int i = 0; i < 5; i++)
        begin
            wdt_enable <= wd[i];
            set_scc({6'h0, kp[i]});
            halt_req <= 1'b1;
            @(posedge hclk);
            halt_req <= 1'b0;
            repeat (3) @(posedge hclk);
            check({29'h0, power_mode}, {29'h0, md[i]});
            check({31'h0, cpu_run}, 32'h0);
            check({30'h0, {osc_on.fast_rc, osc_on.slow_rc} & ((i == 4) ? 2'h2 : 2'h3)}, {30'h0, os[i]});
            bus(1'b1, ADDR_SCC, {30'h0, ~kp[i]});
            @(posedge hclk);
            check({29'h0, power_mode}, {29'h0, md[i]});
            wake_req <= 1'b1;
            @(posedge hclk);
            wake_req <= 1'b0;
            repeat (3) @(posedge hclk);
            check({31'h0, cpu_run}, 32'h1);
        end
        close_out();
    end
endmodule
`default_nettype wire
